/* File: hdl/sco_pkg.sv */
package sco_pkg;

  localparam int SCO_SB_N = 32;
  localparam int SCO_IDX_W = 5;
  localparam int SCO_GPR_W = 4;
  localparam int SCO_LAT_W = 5;
  localparam int SCO_SYS_W = 8;
  localparam int SCO_CNT_W = 4;
  localparam int SCO_ADDR_W = 32;
  localparam int SCO_RAS_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////////
  // issue and result latencies, in core clock cycles
  localparam logic [SCO_LAT_W-1:0] SCO_ONE_CYC = 5'h01;
  localparam logic [SCO_LAT_W-1:0] SCO_TCB_RD_ISS = 5'h02;
  localparam logic [SCO_LAT_W-1:0] SCO_TCB_RD_LAT = 5'h04;
  localparam logic [SCO_LAT_W-1:0] SCO_DBG_RD_ISS = 5'h02;
  localparam logic [SCO_LAT_W-1:0] SCO_DBG_RD_LAT = 5'h04;
  localparam logic [SCO_LAT_W-1:0] SCO_DBG_WR_LAT = 5'h04;
  localparam logic [SCO_LAT_W-1:0] SCO_SYS_WR_LAT = 5'h04;
  localparam logic [SCO_LAT_W-1:0] SCO_SR_LAT = 5'h02;
  localparam logic [SCO_LAT_W-1:0] SCO_TT_LAT = 5'h03;
  localparam logic [SCO_LAT_W-1:0] SCO_CP_LD_LAT = 5'h05;
  localparam logic [SCO_LAT_W-1:0] SCO_CP_ST_LAT = 5'h05;
  localparam logic [SCO_LAT_W-1:0] SCO_MVCR_ISS = 5'h02;
  localparam logic [SCO_LAT_W-1:0] SCO_MVCR_LAT = 5'h04;
  localparam logic [SCO_LAT_W-1:0] SCO_MVRC_LAT = 5'h05;
  localparam logic [SCO_LAT_W-1:0] SCO_LDM_PTR_LAT = 5'h01;
  localparam logic [SCO_LAT_W-1:0] SCO_LDM_DATA_LAT = 5'h02;
  localparam logic [SCO_LAT_W-1:0] SCO_STCM_EXTRA = 5'h01;

  typedef enum logic [4:0] {
    SCO_OP_NONE, SCO_OP_DBG_TO_GPR, SCO_OP_SYS_TO_GPR, SCO_OP_GPR_TO_DBG,
    SCO_OP_GPR_TO_SYS, SCO_OP_GPR_TO_SR, SCO_OP_SR_TO_GPR, SCO_OP_TT_READ,
    SCO_OP_TT_SEARCH, SCO_OP_TT_WRITE, SCO_OP_CACHE, SCO_OP_RAS_FLUSH,
    SCO_OP_PREFETCH, SCO_OP_SLEEP, SCO_OP_WB_FLUSH,
    SCO_OP_COPROC_OPERATION, SCO_OP_CP_LOAD, SCO_OP_CP_LOAD_PRE_IDX,
    SCO_OP_COPROC_ZERO_LOAD_WORD, SCO_OP_COPROC_ZERO_LOAD_DOUBLE,
    SCO_OP_CP_LOAD_MULTI, SCO_OP_CP_TO_GPR, SCO_OP_GPR_TO_CP,
    SCO_OP_COPROC_ZERO_STORE_WORD, SCO_OP_COPROC_ZERO_STORE_DOUBLE,
    SCO_OP_CP_STORE, SCO_OP_CP_STORE_POSTINC, SCO_OP_CP_STORE_MULTI
  } sco_op_t;

  typedef struct packed {
    logic valid;
    sco_op_t op;
    logic [SCO_IDX_W-1:0] dst;
    logic dst_we;
    logic [SCO_IDX_W-1:0] src_a;
    logic src_a_use;
    logic [SCO_IDX_W-1:0] src_b;
    logic src_b_use;
    logic [SCO_GPR_W-1:0] base;
    logic base_we;
    logic [SCO_SYS_W-1:0] sys_num;
    logic sys_tcb;
    logic [SCO_CNT_W-1:0] reg_count;
  } sco_instr_t;

  typedef struct packed {
    logic [SCO_LAT_W-1:0] iss;
    logic [SCO_LAT_W-1:0] res;
    logic [SCO_LAT_W-1:0] base_lat;
  } sco_timing_t;

  typedef struct packed {
    logic issued;
    sco_op_t op;
    logic sys_rd;
    logic sys_wr;
    logic [SCO_SYS_W-1:0] sys_num;
    logic sys_tcb;
    logic tt_read;
    logic tt_search;
    logic tt_write;
    logic cache;
    logic prefetch;
    logic sleep;
    logic wb_flush;
    logic ras_flush;
    logic cp_cmd;
    logic flag_we;
  } sco_cmd_t;

  typedef struct packed {
    logic sys_busy;
    logic sys_any;
    logic [SCO_SYS_W-1:0] sys_num;
    logic sr_busy;
  } sco_status_t;

  typedef struct packed {
    logic [SCO_LAT_W-1:0] cnt;
    logic ready;
    logic fwd;
  } sco_ctr_state_t;

  typedef struct packed {
    logic [SCO_RAS_DEPTH-1:0][SCO_ADDR_W-1:0] stk;
    logic [SCO_RAS_DEPTH-1:0] vld;
    logic [SCO_ADDR_W-1:0] target;
    logic hit;
  } sco_ras_state_t;

endpackage : sco_pkg

/* File: hdl/sco_lat_ctr.sv */
`timescale 1ns/10ps
module sco_lat_ctr (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_load,
  input wire logic [sco_pkg::SCO_LAT_W-1:0] i_lat,
  output logic o_ready,
  output logic o_fwd
);
  import sco_pkg::*;

  sco_ctr_state_t s_reg;
  sco_ctr_state_t s_next;

  // cnt holds cycles left before a consumer may issue; ready is cnt == 0
  always_comb begin
    s_next = s_reg;
    s_next.fwd = 1'b0;
    if (i_load) begin
      s_next.cnt = (i_lat > SCO_ONE_CYC) ? i_lat - SCO_ONE_CYC : '0;
      s_next.ready = (i_lat <= SCO_ONE_CYC);
      s_next.fwd = s_next.ready;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - SCO_ONE_CYC;
      s_next.ready = (s_reg.cnt == SCO_ONE_CYC);
      s_next.fwd = s_next.ready;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '{cnt: '0, ready: 1'b1, fwd: 1'b0};
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  assign o_ready = s_reg.ready;
  assign o_fwd = s_reg.fwd;

endmodule : sco_lat_ctr

/* File: hdl/sco_ras.sv */
`timescale 1ns/10ps
module sco_ras #(
  parameter int DEPTH = sco_pkg::SCO_RAS_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_push,
  input wire logic [sco_pkg::SCO_ADDR_W-1:0] i_push_addr,
  input wire logic i_pop,
  input wire logic i_flush,
  output logic [sco_pkg::SCO_ADDR_W-1:0] o_target,
  output logic o_hit
);
  import sco_pkg::*;

  sco_ras_state_t s_reg;
  sco_ras_state_t s_next;

  // shift stack: entry 0 is the top; oldest entry falls off when full
  always_comb begin
    s_next = s_reg;
    s_next.hit = 1'b0;
    if (i_pop) begin
      s_next.hit = s_reg.vld[0];
      s_next.target = s_reg.stk[0];
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_next.stk[i] = s_reg.stk[i+1];
        s_next.vld[i] = s_reg.vld[i+1];
      end
      s_next.vld[DEPTH-1] = 1'b0;
    end
    if (i_flush) begin
      s_next.vld = '0;
    end
    if (i_push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        s_next.stk[i] = s_next.stk[i-1];
        s_next.vld[i] = s_next.vld[i-1];
      end
      s_next.stk[0] = i_push_addr;
      s_next.vld[0] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  assign o_target = s_reg.target;
  assign o_hit = s_reg.hit;

endmodule : sco_ras

/* File: hdl/sco_latency_ctrl.sv */
`timescale 1ns/10ps
// Behaviour
// - forward results and detect hazards on every general and coprocessor register
// - first-execute-stage system register reads complete in one cycle
// - test-control-bus reads take four cycles, writes issue in one
// - debug register to general register: issue 2, result 4
// - system register read: issue 1 or 2, result 1 or 4 by location
// - general register to debug register: issue 1, effect after 4
// - general register to system register: issue 1, result 4
// - general register to status register: issue 1, visible after 2
// - status register to general register: issue 1, result 2
// - translation table read, search, write: issue 1, result 3
// - system control operations take one cycle, issue and result
// - return-stack flush invalidates every return stack entry
// - four-entry return stack, pushed by calls, popped by returns
// - coprocessor zero load: issue 1, data after 5
// - coprocessor load with predecrement or index: result 5
// - coprocessor load multiple timed like general load multiple
// - load multiple: pointer ready after 1, first data after 2
// - coprocessor to general register: issue 2, result 4
// - general register to coprocessor: issue 1, result 5
// - coprocessor zero store: issue 1, completion 5
// - coprocessor store with post-increment: issue 1, latency 5
// - coprocessor store multiple: one more than store multiple
module sco_latency_ctrl #(
  parameter int SB_N = sco_pkg::SCO_SB_N,
  parameter int RAS_DEPTH = sco_pkg::SCO_RAS_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire sco_pkg::sco_instr_t i_instr,
  input wire logic i_call,
  input wire logic [sco_pkg::SCO_ADDR_W-1:0] i_call_ret_addr,
  input wire logic i_ret_predict,
  output logic o_ready,
  output logic [SB_N-1:0] o_reg_ready,
  output logic [SB_N-1:0] o_fwd,
  output sco_pkg::sco_cmd_t o_cmd,
  output sco_pkg::sco_status_t o_status,
  output logic [sco_pkg::SCO_ADDR_W-1:0] o_ras_target,
  output logic o_ras_hit
);
  import sco_pkg::*;

  typedef struct packed {
    logic ready;
    logic [SCO_LAT_W-1:0] iss_cnt;
    logic [SCO_LAT_W-1:0] sys_cnt;
    logic sys_any;
    logic [SCO_SYS_W-1:0] sys_num;
    logic [SCO_LAT_W-1:0] sr_cnt;
    sco_cmd_t cmd;
    sco_status_t status;
  } sco_core_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // timing table

  function automatic sco_timing_t op_timing(input sco_instr_t ins);
    sco_timing_t t;
    logic [SCO_LAT_W-1:0] cnt;
    t = '{iss: SCO_ONE_CYC, res: SCO_ONE_CYC, base_lat: SCO_ONE_CYC};
    cnt = {1'b0, ins.reg_count};
    // an empty register list still occupies the issue slot once
    if (cnt == '0) begin
      cnt = SCO_ONE_CYC;
    end
    unique case (ins.op)
      SCO_OP_DBG_TO_GPR: begin
        t.iss = SCO_DBG_RD_ISS;
        t.res = SCO_DBG_RD_LAT;
      end
      SCO_OP_SYS_TO_GPR: begin
        if (ins.sys_tcb) begin
          t.iss = SCO_TCB_RD_ISS;
          t.res = SCO_TCB_RD_LAT;
        end else begin
          t.iss = SCO_ONE_CYC;
          t.res = SCO_ONE_CYC;
        end
      end
      SCO_OP_GPR_TO_DBG: t.res = SCO_DBG_WR_LAT;
      SCO_OP_GPR_TO_SYS: t.res = SCO_SYS_WR_LAT;
      SCO_OP_GPR_TO_SR: t.res = SCO_SR_LAT;
      SCO_OP_SR_TO_GPR: t.res = SCO_SR_LAT;
      SCO_OP_TT_READ,
      SCO_OP_TT_SEARCH,
      SCO_OP_TT_WRITE: t.res = SCO_TT_LAT;
      SCO_OP_CACHE,
      SCO_OP_RAS_FLUSH,
      SCO_OP_PREFETCH,
      SCO_OP_SLEEP,
      SCO_OP_WB_FLUSH: t.res = SCO_ONE_CYC;
      SCO_OP_COPROC_OPERATION: t.res = SCO_ONE_CYC;
      SCO_OP_CP_LOAD,
      SCO_OP_COPROC_ZERO_LOAD_WORD,
      SCO_OP_COPROC_ZERO_LOAD_DOUBLE: t.res = SCO_CP_LD_LAT;
      SCO_OP_CP_LOAD_PRE_IDX: t.res = SCO_CP_LD_LAT;
      SCO_OP_CP_LOAD_MULTI: begin
        t.iss = cnt;
        t.res = SCO_LDM_DATA_LAT;
        t.base_lat = SCO_LDM_PTR_LAT;
      end
      SCO_OP_CP_TO_GPR: begin
        t.iss = SCO_MVCR_ISS;
        t.res = SCO_MVCR_LAT;
      end
      SCO_OP_GPR_TO_CP: t.res = SCO_MVRC_LAT;
      SCO_OP_COPROC_ZERO_STORE_WORD,
      SCO_OP_COPROC_ZERO_STORE_DOUBLE,
      SCO_OP_CP_STORE: begin
        t.res = SCO_CP_ST_LAT;
        t.base_lat = SCO_CP_ST_LAT;
      end
      SCO_OP_CP_STORE_POSTINC: begin
        t.res = SCO_CP_ST_LAT;
        t.base_lat = SCO_CP_ST_LAT;
      end
      SCO_OP_CP_STORE_MULTI: begin
        t.iss = cnt + SCO_STCM_EXTRA;
        t.res = SCO_LDM_PTR_LAT + SCO_STCM_EXTRA;
        t.base_lat = SCO_LDM_PTR_LAT + SCO_STCM_EXTRA;
      end
      default: t = '{iss: SCO_ONE_CYC, res: SCO_ONE_CYC,
        base_lat: SCO_ONE_CYC};
    endcase
    return t;
  endfunction : op_timing

  function automatic logic [SCO_LAT_W-1:0] count_down(
    input logic [SCO_LAT_W-1:0] c
  );
    return (c != '0) ? c - SCO_ONE_CYC : '0;
  endfunction : count_down

  function automatic logic [SCO_LAT_W-1:0] arm(
    input logic [SCO_LAT_W-1:0] lat
  );
    return (lat > SCO_ONE_CYC) ? lat - SCO_ONE_CYC : '0;
  endfunction : arm

  ////////////////////////////////////////////////////////////////////////////
  // hazard check and issue

  sco_core_state_t s_reg;
  sco_core_state_t s_next;
  sco_timing_t tm;
  logic [SB_N-1:0] sb_ready;
  logic [SB_N-1:0] sb_load;
  logic [SB_N-1:0][SCO_LAT_W-1:0] sb_lat;
  logic src_hazard;
  logic sys_hazard;
  logic sr_hazard;
  logic do_issue;
  logic is_sys_read;
  logic [SCO_IDX_W-1:0] base_idx;

  assign tm = op_timing(i_instr);
  assign base_idx = {1'b0, i_instr.base};
  assign is_sys_read = (i_instr.op == SCO_OP_DBG_TO_GPR) ||
    (i_instr.op == SCO_OP_SYS_TO_GPR);

  // the ready flags are already registered, so an operand whose latency
  // ends this cycle is taken from the forwarding path without a bubble
  always_comb begin
    src_hazard = 1'b0;
    if (i_instr.src_a_use && !sb_ready[i_instr.src_a]) begin
      src_hazard = 1'b1;
    end
    if (i_instr.src_b_use && !sb_ready[i_instr.src_b]) begin
      src_hazard = 1'b1;
    end
    // write after write: an older, slower write must land first
    if (i_instr.dst_we && !sb_ready[i_instr.dst]) begin
      src_hazard = 1'b1;
    end
    if (i_instr.base_we && !sb_ready[base_idx]) begin
      src_hazard = 1'b1;
    end
  end

  // a pending system register write blocks reads of the same number; a
  // pending table operation touches several registers, so it blocks all
  assign sys_hazard = is_sys_read && (s_reg.sys_cnt != '0) &&
    (s_reg.sys_any || (s_reg.sys_num == i_instr.sys_num));
  assign sr_hazard = (i_instr.op == SCO_OP_SR_TO_GPR) &&
    (s_reg.sr_cnt != '0);
  assign do_issue = i_instr.valid && s_reg.ready && !src_hazard &&
    !sys_hazard && !sr_hazard;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next = s_reg;
    s_next.cmd = '0;
    s_next.iss_cnt = count_down(s_reg.iss_cnt);
    s_next.sys_cnt = count_down(s_reg.sys_cnt);
    s_next.sr_cnt = count_down(s_reg.sr_cnt);
    if (do_issue) begin
      // issue latency n holds the next instruction off for n-1 cycles
      s_next.iss_cnt = arm(tm.iss);
      s_next.cmd.issued = 1'b1;
      s_next.cmd.op = i_instr.op;
      s_next.cmd.sys_num = i_instr.sys_num;
      s_next.cmd.sys_tcb = i_instr.sys_tcb;
      s_next.cmd.flag_we = 1'b0;
      unique case (i_instr.op)
        SCO_OP_DBG_TO_GPR,
        SCO_OP_SYS_TO_GPR: s_next.cmd.sys_rd = 1'b1;
        SCO_OP_GPR_TO_DBG,
        SCO_OP_GPR_TO_SYS: begin
          s_next.cmd.sys_wr = 1'b1;
          s_next.sys_cnt = arm(tm.res);
          s_next.sys_num = i_instr.sys_num;
          s_next.sys_any = 1'b0;
        end
        SCO_OP_GPR_TO_SR: s_next.sr_cnt = arm(tm.res);
        SCO_OP_TT_READ: begin
          s_next.cmd.tt_read = 1'b1;
          s_next.sys_cnt = arm(tm.res);
          s_next.sys_any = 1'b1;
        end
        SCO_OP_TT_SEARCH: begin
          s_next.cmd.tt_search = 1'b1;
          s_next.sys_cnt = arm(tm.res);
          s_next.sys_any = 1'b1;
        end
        SCO_OP_TT_WRITE: begin
          s_next.cmd.tt_write = 1'b1;
          s_next.sys_cnt = arm(tm.res);
          s_next.sys_any = 1'b1;
        end
        SCO_OP_CACHE: s_next.cmd.cache = 1'b1;
        SCO_OP_RAS_FLUSH: s_next.cmd.ras_flush = 1'b1;
        SCO_OP_PREFETCH: s_next.cmd.prefetch = 1'b1;
        SCO_OP_SLEEP: s_next.cmd.sleep = 1'b1;
        SCO_OP_WB_FLUSH: s_next.cmd.wb_flush = 1'b1;
        SCO_OP_COPROC_OPERATION,
        SCO_OP_CP_LOAD,
        SCO_OP_CP_LOAD_PRE_IDX,
        SCO_OP_COPROC_ZERO_LOAD_WORD,
        SCO_OP_COPROC_ZERO_LOAD_DOUBLE,
        SCO_OP_CP_LOAD_MULTI,
        SCO_OP_CP_TO_GPR,
        SCO_OP_GPR_TO_CP,
        SCO_OP_COPROC_ZERO_STORE_WORD,
        SCO_OP_COPROC_ZERO_STORE_DOUBLE,
        SCO_OP_CP_STORE,
        SCO_OP_CP_STORE_POSTINC,
        SCO_OP_CP_STORE_MULTI: s_next.cmd.cp_cmd = 1'b1;
        default: s_next.cmd.issued = 1'b1;
      endcase
    end
    if (s_next.sys_cnt == '0) begin
      s_next.sys_any = 1'b0;
    end
    s_next.ready = (s_next.iss_cnt == '0);
    s_next.status.sys_busy = (s_next.sys_cnt != '0);
    s_next.status.sys_any = s_next.sys_any;
    s_next.status.sys_num = s_next.sys_num;
    s_next.status.sr_busy = (s_next.sr_cnt != '0);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '0;
      s_reg.ready <= 1'b1;
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-register result scoreboard: general registers, then coprocessor

  generate
    for (genvar k = 0; k < SB_N; k++) begin : g_sb
      logic hit_dst;
      logic hit_base;
      assign hit_dst = i_instr.dst_we &&
        (i_instr.dst == SCO_IDX_W'(k));
      assign hit_base = i_instr.base_we && (base_idx == SCO_IDX_W'(k));
      // destination wins if the pointer and a loaded register coincide
      assign sb_load[k] = do_issue && (hit_dst || hit_base);
      assign sb_lat[k] = hit_dst ? tm.res : tm.base_lat;

      sco_lat_ctr u_ctr (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_load(sb_load[k]),
        .i_lat(sb_lat[k]),
        .o_ready(sb_ready[k]),
        .o_fwd(o_fwd[k])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // return address stack; flush acts when the flush instruction issues

  sco_ras #(
    .DEPTH(RAS_DEPTH)
  ) u_ras (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_push(i_call),
    .i_push_addr(i_call_ret_addr),
    .i_pop(i_ret_predict),
    .i_flush(do_issue && (i_instr.op == SCO_OP_RAS_FLUSH)),
    .o_target(o_ras_target),
    .o_hit(o_ras_hit)
  );

  assign o_ready = s_reg.ready;
  assign o_reg_ready = sb_ready;
  assign o_cmd = s_reg.cmd;
  assign o_status = s_reg.status;

endmodule : sco_latency_ctrl

/* File: test/sco_latency_ctrl_props.sv */
`timescale 1ns/10ps
module sco_latency_ctrl_props
  import sco_pkg::*;
#(
  parameter int SB_N = SCO_SB_N
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire sco_pkg::sco_instr_t i_instr,
  input wire logic i_ret_predict,
  input wire logic o_ready,
  input wire logic [SB_N-1:0] o_reg_ready,
  input wire logic [SB_N-1:0] o_fwd,
  input wire sco_pkg::sco_cmd_t o_cmd,
  input wire sco_pkg::sco_status_t o_status,
  input wire logic o_ras_hit
);
  // a frozen core holds every output, so attempts are dropped while stalled
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst || !i_clk_en);

  sequence cmd_s(sco_op_t op);
    o_cmd.issued && o_cmd.op == op;
  endsequence
  sequence two_issue_s;
    !o_ready ##1 o_ready;
  endsequence

  issue_cause_a: assert property (o_cmd.issued && $past(i_clk_en) |->
    $past(i_instr.valid && o_ready)) else $error("issue without request");
  dbg_issue_a: assert property (cmd_s(SCO_OP_DBG_TO_GPR) |-> two_issue_s)
    else $error("debug read issue gap wrong");
  mvcr_issue_a: assert property (cmd_s(SCO_OP_CP_TO_GPR) |-> two_issue_s)
    else $error("coprocessor read issue gap wrong");
  one_issue_a: assert property (o_cmd.issued && (o_cmd.op inside {
    SCO_OP_CACHE, SCO_OP_PREFETCH, SCO_OP_SLEEP, SCO_OP_WB_FLUSH,
    SCO_OP_RAS_FLUSH, SCO_OP_TT_READ, SCO_OP_GPR_TO_CP, SCO_OP_CP_LOAD,
    SCO_OP_GPR_TO_SYS, SCO_OP_SR_TO_GPR, SCO_OP_CP_STORE_POSTINC} ||
    (o_cmd.op == SCO_OP_SYS_TO_GPR && !o_cmd.sys_tcb)) |-> o_ready)
    else $error("single issue op stalled");
  sys_wr_busy_a: assert property (o_cmd.issued && o_cmd.sys_wr |->
    o_status.sys_busy [*3]) else $error("system write busy too short");
  tt_busy_a: assert property (o_cmd.tt_read || o_cmd.tt_write ||
    o_cmd.tt_search |-> (o_status.sys_busy && o_status.sys_any) [*2])
    else $error("table op busy too short");
  sr_busy_a: assert property (cmd_s(SCO_OP_GPR_TO_SR) |-> o_status.sr_busy
    ##1 (!o_status.sr_busy || o_cmd.op == SCO_OP_GPR_TO_SR))
    else $error("status write busy wrong");
  fwd_ready_a: assert property ((o_fwd & ~o_reg_ready) == '0)
    else $error("forward pulse on unready entry");
  ras_hit_a: assert property (o_ras_hit && $past(i_clk_en) |->
    $past(i_ret_predict)) else $error("return stack hit without pop");
  flag_none_a: assert property (o_cmd.flag_we == 1'b0)
    else $error("flag write raised");
endmodule : sco_latency_ctrl_props

bind sco_latency_ctrl sco_latency_ctrl_props #(.SB_N(SB_N)) u_props (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_instr(i_instr), .i_ret_predict(i_ret_predict), .o_ready(o_ready),
  .o_reg_ready(o_reg_ready), .o_fwd(o_fwd), .o_cmd(o_cmd),
  .o_status(o_status), .o_ras_hit(o_ras_hit));

/* File: test/sco_far_model.sv */
`timescale 1ns/10ps
module sco_far_model
  import sco_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire sco_pkg::sco_cmd_t i_cmd,
  output logic [31:0] o_count
);
  // the far side only consumes command pulses; it never back-pressures
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_count <= 32'h00000000;
    end else if (i_clk_en && i_cmd.issued) begin
      o_count <= o_count + 32'h00000001;
    end
  end
endmodule : sco_far_model

/* File: test/sco_latency_ctrl_test.sv */
`timescale 1ns/10ps
module sco_latency_ctrl_test;
  import sco_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  sco_instr_t i_instr = '0;
  logic i_call = 1'b0;
  logic [SCO_ADDR_W-1:0] i_call_ret_addr = '0;
  logic i_ret_predict = 1'b0;
  logic o_ready, o_ras_hit;
  logic [SCO_SB_N-1:0] o_reg_ready, o_fwd;
  sco_cmd_t o_cmd;
  sco_status_t o_status;
  logic [SCO_ADDR_W-1:0] o_ras_target;
  logic [31:0] seed = 32'h079DCFD7;
  logic [31:0] n_far, n_issue = 32'h0;
  logic [31:0] addr [5];
  int n_mismatch = 0;
  int samples_checked = 0;
  always #5 i_clock = ~i_clock;

  sco_latency_ctrl dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en), .i_instr(i_instr), .i_call(i_call),
    .i_call_ret_addr(i_call_ret_addr), .i_ret_predict(i_ret_predict),
    .o_ready(o_ready), .o_reg_ready(o_reg_ready), .o_fwd(o_fwd),
    .o_cmd(o_cmd), .o_status(o_status), .o_ras_target(o_ras_target),
    .o_ras_hit(o_ras_hit));
  sco_far_model far (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en), .i_cmd(o_cmd), .o_count(n_far));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // {kind, issue, result, sys busy, status busy}; kind 1 gpr, 2 cp, 3 base
  function automatic logic [17:0] exp_of(sco_op_t op, logic bus, int cnt);
    logic [3:0] m;
    m = (cnt == 0) ? 4'h1 : 4'(cnt);
    case (op)
      SCO_OP_DBG_TO_GPR, SCO_OP_CP_TO_GPR: return {2'h1, 16'h2400};
      SCO_OP_SYS_TO_GPR: return bus ? {2'h1, 16'h2400} : {2'h1, 16'h1100};
      SCO_OP_GPR_TO_DBG, SCO_OP_GPR_TO_SYS: return {2'h0, 16'h1140};
      SCO_OP_GPR_TO_SR: return {2'h0, 16'h1102};
      SCO_OP_SR_TO_GPR: return {2'h1, 16'h1200};
      SCO_OP_TT_READ, SCO_OP_TT_SEARCH,
      SCO_OP_TT_WRITE: return {2'h0, 16'h1130};
      SCO_OP_CP_LOAD, SCO_OP_CP_LOAD_PRE_IDX, SCO_OP_COPROC_ZERO_LOAD_WORD,
      SCO_OP_COPROC_ZERO_LOAD_DOUBLE,
      SCO_OP_GPR_TO_CP: return {2'h2, 16'h1500};
      SCO_OP_CP_LOAD_MULTI: return {2'h2, m, 12'h200};
      SCO_OP_COPROC_ZERO_STORE_WORD, SCO_OP_COPROC_ZERO_STORE_DOUBLE,
      SCO_OP_CP_STORE, SCO_OP_CP_STORE_POSTINC: return {2'h3, 16'h1500};
      SCO_OP_CP_STORE_MULTI: return {2'h3, m + 4'h1, 12'h200};
      default: return {2'h0, 16'h1100};
    endcase
  endfunction : exp_of

  function automatic logic [31:0] gap(logic [3:0] x);
    return (x == 4'h0) ? 32'h0 : 32'(x - 4'h1);
  endfunction : gap

  function automatic sco_instr_t mk(sco_op_t op, int d, int sn, int s);
    sco_instr_t r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.dst = 5'(d);
    r.dst_we = (d != 0);
    r.sys_num = 8'(sn);
    r.src_a = 5'(s);
    r.src_a_use = (s != 0);
    return r;
  endfunction : mk

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // holds the request until the command pulse shows it was taken
  task automatic issue(sco_instr_t ins, output int w);
    i_instr = ins;
    for (w = 1; w <= 20; w++) begin
      @(negedge i_clock);
      if (o_cmd.issued === 1'b1) begin
        n_issue++;
        return;
      end
    end
    check("issue wait", 32'h0, 32'h1);
    finish_test();
  endtask : issue

  task automatic run_one(sco_op_t op);
    logic [17:0] e;
    logic [31:0] nr, nd, ns, nsr, fat;
    sco_instr_t ins;
    logic bus;
    int cnt, idx, w;
    bus = rnd() % 2;
    cnt = rnd() % 5;
    e = exp_of(op, bus, cnt);
    idx = (e[17:16] == 2'h2) ? 16 + rnd() % 16 : rnd() % 16;
    ins = mk(op, 0, rnd() % 256, 0);
    ins.sys_tcb = bus;
    ins.reg_count = 4'(cnt);
    ins.dst = 5'(idx);
    ins.dst_we = (e[17:16] == 2'h1 || e[17:16] == 2'h2);
    ins.base = 4'(idx);
    ins.base_we = (e[17:16] == 2'h3);
    issue(ins, w);
    check("cmd op", 32'(o_cmd.op), 32'(op));
    check("cmd bits", {o_cmd.cache, o_cmd.prefetch, o_cmd.sleep,
      o_cmd.wb_flush, o_cmd.ras_flush, o_cmd.tt_read, o_cmd.tt_search,
      o_cmd.tt_write}, {op == SCO_OP_CACHE, op == SCO_OP_PREFETCH,
      op == SCO_OP_SLEEP, op == SCO_OP_WB_FLUSH, op == SCO_OP_RAS_FLUSH,
      op == SCO_OP_TT_READ, op == SCO_OP_TT_SEARCH, op == SCO_OP_TT_WRITE});
    check("cmd class", {o_cmd.sys_rd, o_cmd.sys_wr, o_cmd.cp_cmd,
      o_cmd.flag_we}, {op == SCO_OP_DBG_TO_GPR || op == SCO_OP_SYS_TO_GPR,
      op == SCO_OP_GPR_TO_DBG || op == SCO_OP_GPR_TO_SYS,
      op >= SCO_OP_COPROC_OPERATION, 1'b0});
    i_instr.valid = 1'b0;
    {nr, nd, ns, nsr, fat} = '0;
    for (int k = 1; k <= 9; k++) begin
      nr += 32'(!o_ready);
      nd += 32'(!o_reg_ready[idx]);
      ns += 32'(o_status.sys_busy);
      nsr += 32'(o_status.sr_busy);
      if (o_fwd[idx] === 1'b1 && fat == 0) fat = 32'(k);
      @(negedge i_clock);
    end
    check("issue gap", nr, gap(e[15:12]));
    if (e[17:16] != 2'h0) begin
      check("result gap", nd, gap(e[11:8]));
      check("forward cycle", fat, 32'(e[11:8]));
    end
    check("sys busy", ns, gap(e[7:4]));
    check("status busy", nsr, gap(e[3:0]));
  endtask : run_one

  task automatic pair(sco_instr_t a, sco_instr_t b, int exp);
    int w;
    issue(a, w);
    issue(b, w);
    check("dependent wait", 32'(w), 32'(exp));
    i_instr.valid = 1'b0;
    repeat (8) @(negedge i_clock);
  endtask : pair

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge i_clock);
    check("reset ready", {o_ready, o_cmd.issued, o_ras_hit}, 32'h4);
    check("reset scoreboard", o_reg_ready, 32'hFFFFFFFF);
    i_sys_rst = 1'b0;
    @(negedge i_clock);
    for (int p = 0; p < 3; p++) begin
      for (int i = 1; i <= 27; i++) run_one(sco_op_t'(i));
    end
    pair(mk(SCO_OP_CP_TO_GPR, 3, 0, 0), mk(SCO_OP_GPR_TO_SYS, 0, 5, 3), 4);
    pair(mk(SCO_OP_GPR_TO_SYS, 0, 5, 0), mk(SCO_OP_SYS_TO_GPR, 7, 5, 0), 4);
    pair(mk(SCO_OP_GPR_TO_SYS, 0, 5, 0), mk(SCO_OP_SYS_TO_GPR, 7, 6, 0), 1);
    pair(mk(SCO_OP_TT_WRITE, 0, 5, 0), mk(SCO_OP_SYS_TO_GPR, 7, 6, 0), 3);
    pair(mk(SCO_OP_DBG_TO_GPR, 1, 0, 0), mk(SCO_OP_SR_TO_GPR, 2, 0, 0), 2);
    pair(mk(SCO_OP_GPR_TO_DBG, 0, 9, 0), mk(SCO_OP_DBG_TO_GPR, 1, 9, 0), 4);
    pair(mk(SCO_OP_GPR_TO_SR, 0, 0, 0), mk(SCO_OP_SR_TO_GPR, 2, 0, 0), 2);
    pair(mk(SCO_OP_SR_TO_GPR, 4, 0, 0), mk(SCO_OP_GPR_TO_SYS, 0, 1, 4), 2);
    // a low clock enable must hold the pending result count
    begin
      int w;
      issue(mk(SCO_OP_DBG_TO_GPR, 1, 0, 0), w);
      i_instr.valid = 1'b0;
      i_clk_en = 1'b0;
      repeat (5) @(negedge i_clock);
      i_clk_en = 1'b1;
      repeat (2) @(negedge i_clock);
      check("frozen ready", 32'(o_reg_ready[1]), 32'h0);
      @(negedge i_clock);
      check("thawed ready", 32'(o_reg_ready[1]), 32'h1);
      repeat (4) @(negedge i_clock);
    end
    // five pushes into four entries: the oldest is lost
    for (int k = 0; k < 5; k++) begin
      addr[k] = rnd();
      i_call = 1'b1;
      i_call_ret_addr = addr[k];
      @(negedge i_clock);
    end
    i_call = 1'b0;
    i_ret_predict = 1'b1;
    for (int k = 4; k >= 0; k--) begin
      @(negedge i_clock);
      check("stack hit", 32'(o_ras_hit), 32'(k > 0));
      if (k > 0) check("stack target", o_ras_target, addr[k]);
    end
    i_ret_predict = 1'b0;
    i_call = 1'b1;
    @(negedge i_clock);
    i_call = 1'b0;
    run_one(SCO_OP_RAS_FLUSH);
    i_ret_predict = 1'b1;
    @(negedge i_clock);
    i_ret_predict = 1'b0;
    check("flushed stack hit", 32'(o_ras_hit), 32'h0);
    @(negedge i_clock);
    check("far commands", n_far, n_issue);
    finish_test();
  end
endmodule : sco_latency_ctrl_test
